// File: gplc_pkg.sv
package gplc_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] CFG_OFS = 8'h88;
	localparam logic [ADDR_W-1:0] IRQ_STS_OFS = 8'h40;
	localparam logic [ADDR_W-1:0] IRQ_CLR_OFS = 8'h44;
	localparam logic [ADDR_W-1:0] IRQ_EN_OFS = 8'h48;

	// ----------------------------------------
	// Configuration fields
	// ----------------------------------------
	localparam int NPIN = 3;
	localparam int LED_LSB = 28;
	localparam int POL_LSB = 24;
	localparam int EESEL_LSB = 20;
	localparam int BUF_LSB = 16;
	localparam int DIR_LSB = 8;
	localparam int AUX_LSB = 3;
	localparam int VAL_LSB = 0;
	localparam int EESEL_W = 3;
	localparam int AUX_W = 2;
	localparam logic [31:0] CFG_RW_MASK = 32'h7777_071f;
	localparam logic [31:0] CFG_RESET = 32'h0000_0000;
	localparam logic [NPIN-1:0] IRQ_RESET = 3'h0;

	// ----------------------------------------
	// Shared pin function select
	// ----------------------------------------
	typedef enum logic [EESEL_W-1:0] {
		EE_SERIAL = 3'b000,
		EE_AUX_BOTH = 3'b001,
		EE_RSV_A = 3'b010,
		EE_AUX_RXDV = 3'b011,
		EE_RSV_B = 3'b100,
		EE_TXEN_AUX = 3'b101,
		EE_TXEN_RXDV = 3'b110,
		EE_CLOCKS = 3'b111
	} gplc_ee_sel_t;

	// ----------------------------------------
	// Bus handshake states
	// ----------------------------------------
	typedef enum logic [0:0] {
		BUS_IDLE = 1'b0,
		BUS_ACK = 1'b1
	} gplc_bus_state_t;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 25;
	localparam int IGNORE_NS = 40;
	// Activity up to this long may be ignored, so the count rounds down
	localparam int QUAL_CYCLES = (IGNORE_NS / CLK_PERIOD_NS) < 1 ? 1 : (IGNORE_NS / CLK_PERIOD_NS);
	localparam int QUAL_W = 2;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic read;
		logic write;
		logic [ADDR_W-1:0] address;
		logic [3:0] byteenable;
		logic [31:0] writedata;
	} gplc_avl_req_t;

	typedef struct packed {
		logic o;
		logic oe_n;
	} gplc_pin_drv_t;

endpackage

// File: gplc_level_qual.sv
`timescale 1ns/1ps
`default_nettype none

module gplc_level_qual (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [gplc_pkg::NPIN-1:0] level_in,
	input wire logic [gplc_pkg::NPIN-1:0] polarity,
	output logic [gplc_pkg::NPIN-1:0] qualified
);

	// ----------------------------------------
	// Per-pin run counters
	// ----------------------------------------
	logic [gplc_pkg::QUAL_W-1:0] run [gplc_pkg::NPIN];
	localparam logic [gplc_pkg::QUAL_W-1:0] RUN_MAX = gplc_pkg::QUAL_W'(gplc_pkg::QUAL_CYCLES);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < gplc_pkg::NPIN; i++) begin
				run[i] <= '0;
			end
		end else begin
			for (int i = 0; i < gplc_pkg::NPIN; i++) begin
				// Glitches shorter than the window restart the count [RQ4]
				if (level_in[i] != polarity[i]) begin
					run[i] <= '0;
				end else if (run[i] != RUN_MAX) begin
					run[i] <= run[i] + 1'b1;
				end
			end
		end
	end

	always_comb begin
		for (int i = 0; i < gplc_pkg::NPIN; i++) begin
			qualified[i] = (run[i] == RUN_MAX); // [RQ2] [RQ4]
		end
	end

endmodule

`default_nettype wire

// File: gplc_pin_config.sv
// Notes on behaviour
// [RQ1] Each LED bit puts its pin on the LED signal; low bit is pin 0.
// [RQ2] Polarity bit one: high level sets status; zero: low level sets it.
// [RQ3] Pin interrupt reaches host only when its enable bit is set too.
// [RQ4] Levels held over forty nanoseconds are surely seen; shorter may be dropped.
// [RQ5] Three-bit select picks serial, aux outputs, or debug signals on shared pins.
// [RQ6] Software keeps select steady during serial transfers and avoids reserved codes.
// [RQ7] Buffer bit one gives push-pull drive, zero gives open-drain.
// [RQ8] Direction bit one makes pin an output, zero an input.
// [RQ9] Two aux data bits drive the shared pins when selected there.
// [RQ10] Data bits drive output pins; reads return sampled pin levels.
// [RQ11] All configuration fields reset to zero.
// [RQ12] In LED mode direction, buffer type and data bits do not matter.
`timescale 1ns/1ps
`default_nettype none

module gplc_pin_config (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [gplc_pkg::ADDR_W-1:0] avl_address,
	input wire logic avl_read,
	input wire logic avl_write,
	input wire logic [3:0] avl_byteenable,
	input wire logic [31:0] avl_writedata,
	output logic [31:0] avl_readdata,
	output logic avl_waitrequest,
	output logic irq,
	input wire logic [gplc_pkg::NPIN-1:0] gpio_in,
	output logic [gplc_pkg::NPIN-1:0] gpio_out,
	output logic [gplc_pkg::NPIN-1:0] gpio_oe_n,
	input wire logic [gplc_pkg::NPIN-1:0] led_state,
	input wire logic eeprom_serial_data_in,
	output logic eeprom_serial_data_out,
	output logic eeprom_serial_data_oe_n,
	output logic eeprom_serial_clock_out,
	output logic eeprom_serial_clock_oe_n,
	output logic eectl_data_in,
	input wire logic eectl_data_out,
	input wire logic eectl_data_oe_n,
	input wire logic eectl_clock,
	input wire logic mii_tx_en,
	input wire logic mii_rx_dv,
	input wire logic mii_tx_clk,
	input wire logic mii_rx_clk
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] lane_mask(input logic [3:0] be);
		logic [31:0] m;
		m = '0;
		for (int b = 0; b < 4; b++) begin
			m[b*8 +: 8] = {8{be[b]}};
		end
		return m;
	endfunction

	function automatic gplc_pkg::gplc_pin_drv_t pin_drive(
		input logic led_on,
		input logic led_val,
		input logic dir_out,
		input logic push_pull,
		input logic val
	);
		gplc_pkg::gplc_pin_drv_t d;
		d.o = 1'b0;
		d.oe_n = 1'b1;
		if (led_on) begin
			// LED owns the pin regardless of the other fields [RQ1] [RQ12]
			d.o = led_val;
			d.oe_n = 1'b0;
		end else if (dir_out) begin // [RQ8]
			if (push_pull) begin // [RQ7]
				d.o = val;
				d.oe_n = 1'b0;
			end else begin
				// Open-drain only pulls low; a one releases the pin [RQ7]
				d.o = 1'b0;
				d.oe_n = val;
			end
		end
		return d;
	endfunction

	// ----------------------------------------
	// Bus request
	// ----------------------------------------
	gplc_pkg::gplc_avl_req_t req;
	gplc_pkg::gplc_bus_state_t state;
	gplc_pkg::gplc_bus_state_t next_state;
	logic active;
	logic commit_wr;
	logic [31:0] wmask;

	always_comb begin
		req.read = avl_read;
		req.write = avl_write;
		req.address = avl_address;
		req.byteenable = avl_byteenable;
		req.writedata = avl_writedata;
	end

	assign active = req.read | req.write;
	assign wmask = lane_mask(req.byteenable);
	// One wait cycle, then the request completes at the following edge
	assign avl_waitrequest = active && (state != gplc_pkg::BUS_ACK);
	// Writes land on the edge that ends the BUS_ACK cycle, one edge after the wait cycle ends
	assign commit_wr = req.write && (state == gplc_pkg::BUS_ACK);

	always_comb begin
		next_state = state;
		case (state)
			gplc_pkg::BUS_IDLE: begin
				if (active) begin
					next_state = gplc_pkg::BUS_ACK;
				end
			end
			gplc_pkg::BUS_ACK: begin
				next_state = gplc_pkg::BUS_IDLE;
			end
			default: begin
				next_state = gplc_pkg::BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= gplc_pkg::BUS_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// ----------------------------------------
	// Configuration register
	// ----------------------------------------
	logic [31:0] cfg;
	logic [gplc_pkg::NPIN-1:0] led_select;
	logic [gplc_pkg::NPIN-1:0] pin_irq_polarity;
	logic [gplc_pkg::NPIN-1:0] pin_buffer_type;
	logic [gplc_pkg::NPIN-1:0] pin_direction;
	logic [gplc_pkg::NPIN-1:0] pin_value;
	logic [gplc_pkg::AUX_W-1:0] aux_output_value;
	gplc_pkg::gplc_ee_sel_t eeprom_pin_select;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cfg <= gplc_pkg::CFG_RESET; // [RQ11]
		end else if (commit_wr && req.address == gplc_pkg::CFG_OFS) begin
			// Select changes mid-transfer are the software's to avoid [RQ6]
			cfg <= (cfg & ~(wmask & gplc_pkg::CFG_RW_MASK)) | (req.writedata & wmask & gplc_pkg::CFG_RW_MASK);
		end
	end

	assign led_select = cfg[gplc_pkg::LED_LSB +: gplc_pkg::NPIN];
	assign pin_irq_polarity = cfg[gplc_pkg::POL_LSB +: gplc_pkg::NPIN];
	assign eeprom_pin_select = gplc_pkg::gplc_ee_sel_t'(cfg[gplc_pkg::EESEL_LSB +: gplc_pkg::EESEL_W]);
	assign pin_buffer_type = cfg[gplc_pkg::BUF_LSB +: gplc_pkg::NPIN];
	assign pin_direction = cfg[gplc_pkg::DIR_LSB +: gplc_pkg::NPIN];
	assign aux_output_value = cfg[gplc_pkg::AUX_LSB +: gplc_pkg::AUX_W];
	assign pin_value = cfg[gplc_pkg::VAL_LSB +: gplc_pkg::NPIN];

	// ----------------------------------------
	// Pin sampling and qualification
	// ----------------------------------------
	// Single stage only: pins are taken as synchronous to clk
	logic [gplc_pkg::NPIN-1:0] pin_sample;
	logic [gplc_pkg::NPIN-1:0] pin_qual;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_sample <= '0;
		end else begin
			pin_sample <= gpio_in; // [RQ10]
		end
	end

	// Levels shorter than the qualify window may be dropped [RQ4]
	gplc_level_qual u_qual (
		.clk(clk),
		.arst_n(arst_n),
		.level_in(pin_sample),
		.polarity(pin_irq_polarity),
		.qualified(pin_qual)
	);

	// ----------------------------------------
	// Interrupt status, enable and clear
	// ----------------------------------------
	logic [gplc_pkg::NPIN-1:0] irq_status_reg;
	logic [gplc_pkg::NPIN-1:0] pin_irq_enable;
	logic [gplc_pkg::NPIN-1:0] irq_clear;
	logic [gplc_pkg::NPIN-1:0] irq_cause;

	assign irq_clear = (commit_wr && req.address == gplc_pkg::IRQ_CLR_OFS) ?
		(req.writedata[gplc_pkg::NPIN-1:0] & wmask[gplc_pkg::NPIN-1:0]) : '0;
	// An LED pin is not a general input, so it raises nothing
	assign irq_cause = pin_qual & ~led_select; // [RQ2]

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_status_reg <= gplc_pkg::IRQ_RESET;
		end else begin
			// A cause present in the clear cycle keeps the bit set
			irq_status_reg <= (irq_status_reg & ~irq_clear) | irq_cause; // [RQ2]
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_irq_enable <= gplc_pkg::IRQ_RESET;
		end else if (commit_wr && req.address == gplc_pkg::IRQ_EN_OFS) begin
			pin_irq_enable <= (pin_irq_enable & ~wmask[gplc_pkg::NPIN-1:0]) |
				(req.writedata[gplc_pkg::NPIN-1:0] & wmask[gplc_pkg::NPIN-1:0]);
		end
	end

	// Level output: stays high until software clears or masks the bit
	assign irq = |(irq_status_reg & pin_irq_enable); // [RQ3]

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	logic [31:0] rd_word;

	always_comb begin
		rd_word = '0;
		case (req.address)
			gplc_pkg::CFG_OFS: begin
				rd_word = cfg & gplc_pkg::CFG_RW_MASK;
				// Data bits read back the pin, not the written value
				rd_word[gplc_pkg::VAL_LSB +: gplc_pkg::NPIN] = pin_sample; // [RQ10]
			end
			gplc_pkg::IRQ_STS_OFS: begin
				rd_word[gplc_pkg::NPIN-1:0] = irq_status_reg;
			end
			gplc_pkg::IRQ_CLR_OFS: begin
				// Clear register is write-only
				rd_word = '0;
			end
			gplc_pkg::IRQ_EN_OFS: begin
				rd_word[gplc_pkg::NPIN-1:0] = pin_irq_enable;
			end
			default: begin
				rd_word = '0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			avl_readdata <= '0;
		end else if (req.read && state == gplc_pkg::BUS_IDLE) begin
			avl_readdata <= rd_word;
		end
	end

	// ----------------------------------------
	// General pins
	// ----------------------------------------
	gplc_pkg::gplc_pin_drv_t gp_drv [gplc_pkg::NPIN];

	always_comb begin
		for (int i = 0; i < gplc_pkg::NPIN; i++) begin
			gp_drv[i] = pin_drive(led_select[i], led_state[i], pin_direction[i],
				pin_buffer_type[i], pin_value[i]); // [RQ1] [RQ10] [RQ12]
			gpio_out[i] = gp_drv[i].o;
			gpio_oe_n[i] = gp_drv[i].oe_n;
		end
	end

	// ----------------------------------------
	// Shared serial pins
	// ----------------------------------------
	gplc_pkg::gplc_pin_drv_t data_drv;
	gplc_pkg::gplc_pin_drv_t clock_drv;
	logic serial_mode;

	assign serial_mode = (eeprom_pin_select == gplc_pkg::EE_SERIAL);
	// Controller sees a released line when the pin is taken elsewhere
	assign eectl_data_in = serial_mode ? eeprom_serial_data_in : 1'b1;

	always_comb begin
		data_drv.o = 1'b0;
		data_drv.oe_n = 1'b1;
		clock_drv.o = 1'b0;
		clock_drv.oe_n = 1'b1;
		case (eeprom_pin_select) // [RQ5]
			gplc_pkg::EE_SERIAL: begin
				data_drv.o = eectl_data_out;
				data_drv.oe_n = eectl_data_oe_n;
				clock_drv.o = eectl_clock;
				clock_drv.oe_n = 1'b0;
			end
			gplc_pkg::EE_AUX_BOTH: begin
				data_drv.o = aux_output_value[0]; // [RQ9]
				data_drv.oe_n = 1'b0;
				clock_drv.o = aux_output_value[1]; // [RQ9]
				clock_drv.oe_n = 1'b0;
			end
			gplc_pkg::EE_AUX_RXDV: begin
				data_drv.o = aux_output_value[0]; // [RQ9]
				data_drv.oe_n = 1'b0;
				clock_drv.o = mii_rx_dv;
				clock_drv.oe_n = 1'b0;
			end
			gplc_pkg::EE_TXEN_AUX: begin
				data_drv.o = mii_tx_en;
				data_drv.oe_n = 1'b0;
				clock_drv.o = aux_output_value[1]; // [RQ9]
				clock_drv.oe_n = 1'b0;
			end
			gplc_pkg::EE_TXEN_RXDV: begin
				data_drv.o = mii_tx_en;
				data_drv.oe_n = 1'b0;
				clock_drv.o = mii_rx_dv;
				clock_drv.oe_n = 1'b0;
			end
			gplc_pkg::EE_CLOCKS: begin
				// Debug clocks pass straight through; no retiming on this path
				data_drv.o = mii_tx_clk;
				data_drv.oe_n = 1'b0;
				clock_drv.o = mii_rx_clk;
				clock_drv.oe_n = 1'b0;
			end
			default: begin
				// Reserved codes leave both pins released [RQ6]
				data_drv.oe_n = 1'b1;
				clock_drv.oe_n = 1'b1;
			end
		endcase
	end

	assign eeprom_serial_data_out = data_drv.o;
	assign eeprom_serial_data_oe_n = data_drv.oe_n;
	assign eeprom_serial_clock_out = clock_drv.o;
	assign eeprom_serial_clock_oe_n = clock_drv.oe_n;

endmodule

`default_nettype wire

// File: gplc_pin_config_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module gplc_pin_config_asserts (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [gplc_pkg::ADDR_W-1:0] avl_address,
	input wire logic avl_write,
	input wire logic [3:0] avl_byteenable,
	input wire logic [31:0] avl_writedata,
	input wire logic avl_waitrequest,
	input wire logic irq,
	input wire logic [gplc_pkg::NPIN-1:0] gpio_in,
	input wire logic [gplc_pkg::NPIN-1:0] gpio_out,
	input wire logic [gplc_pkg::NPIN-1:0] gpio_oe_n,
	input wire logic [gplc_pkg::NPIN-1:0] led_state,
	input wire logic eeprom_serial_data_out,
	input wire logic eeprom_serial_clock_out,
	input wire logic eectl_data_out,
	input wire logic eectl_clock,
	input wire logic mii_tx_clk,
	input wire logic mii_rx_clk
);
	// ----
	// Shadow registers
	// ----
	// Registers are not visible here, so completed writes are replayed
	logic [31:0] cfg;
	logic [2:0] en;
	logic [31:0] bm;
	logic [2:0] led, dir, pp, val, hit;
	logic wr;
	assign wr = avl_write & ~avl_waitrequest;
	assign bm = {{8{avl_byteenable[3]}}, {8{avl_byteenable[2]}}, {8{avl_byteenable[1]}}, {8{avl_byteenable[0]}}};
	assign led = cfg[30:28];
	assign dir = cfg[10:8];
	assign pp = cfg[18:16];
	assign val = cfg[2:0];
	assign hit = ~(gpio_in ^ cfg[26:24]) & en & ~led;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cfg <= 32'h0;
			en <= 3'h0;
		end else if (wr && avl_address == gplc_pkg::CFG_OFS) begin
			cfg <= (cfg & ~bm) | (avl_writedata & bm & gplc_pkg::CFG_RW_MASK);
		end else if (wr && avl_address == gplc_pkg::IRQ_EN_OFS && avl_byteenable[0]) begin
			en <= avl_writedata[2:0];
		end
	end
	// ----
	// Properties
	// ----
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	// The same pin must match for three samples; mixed pins prove nothing
	sequence s_level_held;
		(|(hit & $past(hit) & $past(hit, 2)));
	endsequence
	a_irq_level_seen: assert property (s_level_held |=> irq) else $error("irq missing");
	a_irq_all_masked: assert property (en == 3'h0 |-> !irq) else $error("irq while masked");
	a_led_drive: assert property (((gpio_oe_n | (gpio_out ^ led_state)) & led) == 3'h0) else $error("led pin");
	a_input_released: assert property ((gpio_oe_n | led | dir) == 3'h7) else $error("input driven");
	a_push_pull_drive: assert property (((gpio_oe_n | (gpio_out ^ val)) & dir & pp & ~led) == 3'h0) else $error("pp");
	a_open_drain_drive: assert property (((gpio_out | (gpio_oe_n ^ val)) & dir & ~pp & ~led) == 3'h0) else $error("od");
	a_aux_route: assert property (cfg[22:20] == 3'h1 |-> eeprom_serial_data_out == cfg[3] && eeprom_serial_clock_out == cfg[4])
		else $error("aux route");
	a_clock_route: assert property (cfg[22:20] == 3'h7 |-> eeprom_serial_data_out == mii_tx_clk && eeprom_serial_clock_out == mii_rx_clk)
		else $error("clock route");
	a_serial_route: assert property (cfg[22:20] == 3'h0 |-> eeprom_serial_data_out == eectl_data_out && eeprom_serial_clock_out == eectl_clock)
		else $error("serial route");
	a_reset_idle: assert property ($rose(arst_n) |-> gpio_oe_n == 3'h7 && !irq) else $error("reset state");
endmodule

bind gplc_pin_config gplc_pin_config_asserts u_chk (.clk, .arst_n, .avl_address, .avl_write, .avl_byteenable,
	.avl_writedata, .avl_waitrequest, .irq, .gpio_in, .gpio_out, .gpio_oe_n, .led_state, .eeprom_serial_data_out,
	.eeprom_serial_clock_out, .eectl_data_out, .eectl_clock, .mii_tx_clk, .mii_rx_clk);

`default_nettype wire

// File: gplc_board_model.sv
`timescale 1ns/1ps
`default_nettype none

module gplc_board_model (
	input wire logic [gplc_pkg::NPIN-1:0] gpio_out,
	input wire logic [gplc_pkg::NPIN-1:0] gpio_oe_n,
	input wire logic [gplc_pkg::NPIN-1:0] ext_level,
	input wire logic eeprom_serial_data_out,
	input wire logic eeprom_serial_data_oe_n,
	output logic [gplc_pkg::NPIN-1:0] gpio_in,
	output logic eeprom_serial_data_in
);
	// ----
	// Pin levels
	// ----
	// A driven pin wins; a released one shows the board source
	assign gpio_in = (gpio_out & ~gpio_oe_n) | (ext_level & gpio_oe_n);
	// Data line has a pull-up, so a released line reads high
	assign eeprom_serial_data_in = eeprom_serial_data_oe_n | eeprom_serial_data_out;
endmodule

`default_nettype wire

// File: gplc_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin bad_count++; $display("mismatch %s exp %h got %h", n, e, s); end end

module tb;
	// ----
	// Bench
	// ----
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	gplc_pkg::gplc_avl_req_t req = '0;
	logic [31:0] rdata, q;
	logic waitreq, irq, ee_do, ee_doe, ee_co, ee_coe, ee_di, ee_ci;
	logic [2:0] gin, gout, goe;
	logic [2:0] ext = 3'h0;
	logic [2:0] led = 3'h0;
	logic [6:0] src = 7'b0010110;
	int checks = 0;
	int bad_count = 0;
	localparam logic [5:0] DEXP = 6'b100110;
	localparam logic [5:0] CEXP = 6'b010101;
	always #12.5 clk = ~clk;
	gplc_pin_config DUT (.clk(clk), .arst_n(arst_n), .avl_address(req.address), .avl_read(req.read),
		.avl_write(req.write), .avl_byteenable(req.byteenable), .avl_writedata(req.writedata), .avl_readdata(rdata),
		.avl_waitrequest(waitreq), .irq(irq), .gpio_in(gin), .gpio_out(gout), .gpio_oe_n(goe), .led_state(led),
		.eeprom_serial_data_in(ee_di), .eeprom_serial_data_out(ee_do), .eeprom_serial_data_oe_n(ee_doe),
		.eeprom_serial_clock_out(ee_co), .eeprom_serial_clock_oe_n(ee_coe), .eectl_data_in(ee_ci),
		.eectl_data_out(src[6]), .eectl_data_oe_n(src[5]), .eectl_clock(src[4]), .mii_tx_en(src[3]),
		.mii_rx_dv(src[2]), .mii_tx_clk(src[1]), .mii_rx_clk(src[0]));
	gplc_board_model u_board (.gpio_out(gout), .gpio_oe_n(goe), .ext_level(ext), .eeprom_serial_data_out(ee_do),
		.eeprom_serial_data_oe_n(ee_doe), .gpio_in(gin), .eeprom_serial_data_in(ee_di));
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		req <= '{!w, w, a, 4'hf, d};
		do @(posedge clk); while (waitreq);
		q = rdata;
		req <= '0;
		@(negedge clk);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string n);
		bus(1'b0, a, 32'h0);
		`CHK(n, e, q)
	endtask
	task automatic t_reset;
		rd_chk(gplc_pkg::CFG_OFS, 32'h0, "cfg");
		`CHK("oe_n", 3'h7, goe)
		rd_chk(gplc_pkg::IRQ_EN_OFS, 32'h0, "en");
		rd_chk(8'h10, 32'h0, "unmapped");
	endtask
	task automatic t_pins;
		@(posedge clk);
		ext <= 3'h2;
		bus(1'b1, gplc_pkg::CFG_OFS, 32'h0003_0705);
		`CHK("out", 3'h1, gout)
		`CHK("oe_n", 3'h4, goe)
		rd_chk(gplc_pkg::CFG_OFS, 32'h0003_0701, "cfg pins");
		bus(1'b1, gplc_pkg::CFG_OFS, 32'h0003_0005);
		`CHK("oe_n", 3'h7, goe)
		rd_chk(gplc_pkg::CFG_OFS, 32'h0003_0002, "cfg inputs");
	endtask
	task automatic t_led;
		@(posedge clk);
		led <= 3'h5;
		bus(1'b1, gplc_pkg::CFG_OFS, 32'h1007_0700);
		`CHK("out", 3'h1, gout)
		`CHK("oe_n", 3'h0, goe)
		bus(1'b1, gplc_pkg::CFG_OFS, 32'h7000_0000);
		`CHK("out", 3'h5, gout)
		`CHK("oe_n", 3'h0, goe)
	endtask
	task automatic t_eesel;
		logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h6, 3'h7};
		for (int j = 0; j < 2; j++) begin
			for (int i = 0; i < 6; i++) begin
				bus(1'b1, gplc_pkg::CFG_OFS, {9'h0, codes[i], 15'h0, j[0] ? 2'h2 : 2'h1, 3'h0});
				`CHK("data", DEXP[i] ^ j[0], ee_do)
				`CHK("clock", CEXP[i] ^ j[0], ee_co)
				`CHK("clock oe", 1'b0, ee_coe)
				`CHK("data oe", (i == 0) ? j[0] : 1'b0, ee_doe)
				`CHK("ctl data", (i == 0) ? j[0] : 1'b1, ee_ci)
			end
			// Serial engine idle while the select moves
			bus(1'b1, gplc_pkg::CFG_OFS, 32'h0);
			@(posedge clk);
			src <= ~src;
		end
	endtask
	task automatic t_irq;
		@(posedge clk);
		ext <= 3'h7;
		bus(1'b1, gplc_pkg::CFG_OFS, 32'h0100_0000);
		// Level held well past the qualify time
		repeat (4) @(posedge clk);
		bus(1'b1, gplc_pkg::IRQ_CLR_OFS, 32'h7);
		repeat (4) @(posedge clk);
		rd_chk(gplc_pkg::IRQ_STS_OFS, 32'h1, "status high");
		`CHK("irq masked", 1'b0, irq)
		bus(1'b1, gplc_pkg::IRQ_EN_OFS, 32'h1);
		`CHK("irq enabled", 1'b1, irq)
		@(posedge clk);
		ext <= 3'h5;
		repeat (4) @(posedge clk);
		rd_chk(gplc_pkg::IRQ_STS_OFS, 32'h3, "status low");
		@(posedge clk);
		ext <= 3'h6;
		repeat (4) @(posedge clk);
		bus(1'b1, gplc_pkg::IRQ_CLR_OFS, 32'h7);
		rd_chk(gplc_pkg::IRQ_STS_OFS, 32'h0, "status clear");
		`CHK("irq clear", 1'b0, irq)
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		t_reset;
		t_pins;
		t_led;
		t_eesel;
		t_irq;
		complete_run;
	end
	// Whole run needs well under a thousand cycles
	initial begin
		repeat (3000) @(posedge clk);
		bad_count++;
		complete_run;
	end
endmodule

`default_nettype wire
